// File: core/byte_op_instruction_exec.sv
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module byte_op_instruction_exec
    import exec_pkg::*;
(
    // clock and reset
    input  wire logic                           i_clk,
    input  wire logic                           i_nrst,
    // register port
    input  wire logic [exec_pkg::REG_AW-1:0]    i_reg_addr,
    input  wire logic [exec_pkg::DATA_W-1:0]    i_reg_wdata,
    input  wire logic                           i_reg_wr,
    input  wire logic                           i_reg_rd,
    output logic      [exec_pkg::DATA_W-1:0]    o_reg_rdata,
    // instruction fetch
    output logic      [exec_pkg::PC_W-1:0]      o_fetch_pc,
    output logic                                o_fetch_req,
    input  wire logic [exec_pkg::WORD_W-1:0]    i_fetch_word,
    // return stack
    output logic                                o_stack_push,
    output logic      [exec_pkg::PC_W-1:0]      o_stack_data,
    // progress
    output logic                                o_cycle_done
);
    import exec_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    phase_type                phase_q;
    logic [WORD_W-1:0]        word_q;
    logic [PC_W-1:0]          pc_q;
    logic [DATA_W-1:0]        acc_q;
    status_type               status_q;
    logic [DATA_W-1:0]        pc_latch_q;
    logic [DATA_W-1:0]        control_q;
    logic                     flush_q;
    logic                     dead_q;
    logic                     stack_push_q;
    logic [PC_W-1:0]          stack_data_q;
    logic                     cycle_done_q;
    logic [DATA_W-1:0]        rdata_q;
    reg_req_type              req;

    logic                     run;
    logic                     commit;
    logic                     fetch;
    op_type                   op;
    logic [FILE_AW-1:0]       file_addr;
    logic                     dest_file;
    logic [DATA_W-1:0]        operand;
    logic [DATA_W-1:0]        operand_raw;
    logic [DATA_W-1:0]        result;
    logic                     result_zero;
    logic                     routed;
    logic                     acc_wr;
    logic                     file_wr;
    logic                     wdt_clear;
    logic                     wdt_expire;
    logic [WDT_COUNT_W-1:0]   wdt_count;
    logic [PC_W-1:0]          pc_next;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    function automatic op_type decode_op(input logic [WORD_W-1:0] w);
        op_type k;
        k = OPK_NOP;
        if (w == OP_CLEAR_WATCHDOG) begin
            k = OPK_CLEAR_WDT;
        end else if ((w & MASK_CALL_OP) == OP_CALL) begin
            k = OPK_CALL;
        end else if ((w & MASK_BYTE_OP) == OP_COMPLEMENT_FILE) begin
            k = OPK_COMPLEMENT;
        end else if ((w & MASK_BYTE_OP) == OP_DECREMENT_FILE) begin
            k = OPK_DECREMENT;
        end else if ((w & MASK_BYTE_OP) == OP_DEC_SKIP_ZERO) begin
            k = OPK_DEC_SKIP;
        end else if ((w & MASK_CLEAR_OP) == OP_CLEAR_FILE) begin
            k = OPK_CLEAR_FILE;
        end else if ((w & MASK_CLEAR_OP) == OP_CLEAR_ACC) begin
            k = OPK_CLEAR_ACC;
        end
        return k;
    endfunction : decode_op

    assign req       = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};
    assign run       = control_q[RUN_BIT];
    assign fetch     = run && (phase_q == PH_FETCH);
    assign commit    = run && (phase_q == PH_COMMIT);
    assign op        = decode_op(word_q);
    assign file_addr = word_q[FILE_AW-1:0];
    assign dest_file = word_q[DEST_BIT];
    assign operand   = operand_raw;

    ////////////////////////////////////////////////////////////////////////////
    // operand memory
    file_ram #(
        .WIDTH (DATA_W),
        .DEPTH (FILE_DEPTH),
        .AW    (FILE_AW)
    ) u_file_ram (
        .i_clk     (i_clk),
        .i_nrst    (i_nrst),
        .i_rd_en   (run && (phase_q == PH_READ)),
        .i_rd_addr (file_addr),
        .o_rd_data (operand_raw),
        .i_wr_en   (file_wr),
        .i_wr_addr (file_addr),
        .i_wr_data (result)
    );

    ////////////////////////////////////////////////////////////////////////////
    // watchdog
    assign wdt_clear = commit && (op == OPK_CLEAR_WDT);

    watchdog_count #(
        .COUNT_W    (WDT_COUNT_W),
        .PRESCALE_W (WDT_PRESCALE_W)
    ) u_watchdog (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_tick   (commit),
        .i_clear  (wdt_clear),
        .o_count  (wdt_count),
        .o_expire (wdt_expire)
    );

    ////////////////////////////////////////////////////////////////////////////
    // result path
    always_comb begin
        case (op)
            OPK_COMPLEMENT: result = ~operand;
            OPK_DECREMENT:  result = operand - 8'h01;
            OPK_DEC_SKIP:   result = operand - 8'h01;
            OPK_CLEAR_FILE: result = 8'h00;
            OPK_CLEAR_ACC:  result = 8'h00;
            default:        result = 8'h00;
        endcase
    end

    assign result_zero = (result == 8'h00);
    assign routed      = (op == OPK_COMPLEMENT) || (op == OPK_DECREMENT) || (op == OPK_DEC_SKIP);
    assign acc_wr      = commit && ((routed && !dest_file) || (op == OPK_CLEAR_ACC));
    assign file_wr     = commit && ((routed && dest_file) || (op == OPK_CLEAR_FILE));

    ////////////////////////////////////////////////////////////////////////////
    // program counter sequencing
    always_comb begin
        case (op)
            OPK_CALL: begin
                pc_next = {pc_latch_q[LATCH_HI:LATCH_LO], word_q[CALL_W-1:0]};
            end
            OPK_DEC_SKIP: begin
                pc_next = result_zero ? pc_q + 13'h0002 : pc_q + 13'h0001;
            end
            default: begin
                pc_next = pc_q + 13'h0001;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // phase of the instruction cycle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_q <= PH_FETCH;
        end else if (run) begin
            case (phase_q)
                PH_FETCH:  phase_q <= PH_READ;
                PH_READ:   phase_q <= PH_EXEC;
                PH_EXEC:   phase_q <= PH_COMMIT;
                PH_COMMIT: phase_q <= PH_FETCH;
                default:   phase_q <= PH_FETCH;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction latch; a pending flush turns the cycle into a dead one
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            word_q  <= WORD_NOP;
            flush_q <= 1'b0;
            dead_q  <= 1'b0;
        end else begin
            if (fetch) begin
                word_q  <= flush_q ? WORD_NOP : i_fetch_word;
                flush_q <= 1'b0;
                dead_q  <= flush_q;
            end else if (commit) begin
                flush_q <= (op == OPK_CALL) || ((op == OPK_DEC_SKIP) && result_zero);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter and return stack push
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pc_q         <= PC_RST;
            stack_push_q <= 1'b0;
            stack_data_q <= PC_RST;
        end else begin
            stack_push_q <= commit && (op == OPK_CALL);
            if (commit && (op == OPK_CALL)) begin
                stack_data_q <= pc_q + 13'h0001;
            end
            // a dead cycle holds the pc on the call target or the skip address
            if (commit && !dead_q) begin
                pc_q <= pc_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // accumulator
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_q <= ACC_RST;
        end else if (acc_wr) begin
            acc_q <= result;
        end else if (req.wr && req.addr == REG_ACC) begin
            acc_q <= req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status; hardware updates win over a software write in the same cycle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_q <= status_type'(STATUS_RST);
        end else begin
            if (req.wr && req.addr == REG_STATUS) begin
                status_q <= status_type'(req.wdata);
            end
            if (commit) begin
                case (op)
                    OPK_CLEAR_WDT: begin
                        status_q.watchdog_expiry_flag_n <= 1'b1;
                        status_q.sleep_flag_n           <= 1'b1;
                    end
                    OPK_COMPLEMENT: status_q.result_null_flag <= result_zero;
                    OPK_DECREMENT:  status_q.result_null_flag <= result_zero;
                    OPK_CLEAR_FILE: status_q.result_null_flag <= 1'b1;
                    OPK_CLEAR_ACC:  status_q.result_null_flag <= 1'b1;
                    default: begin
                    end
                endcase
            end
            if (wdt_expire) begin
                status_q.watchdog_expiry_flag_n <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pc_latch_q <= PC_LATCH_RST;
            control_q  <= CONTROL_RST;
        end else if (req.wr) begin
            if (req.addr == REG_PC_LATCH) begin
                pc_latch_q <= req.wdata;
            end
            if (req.addr == REG_CONTROL) begin
                control_q <= req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                REG_ACC:       rdata_q <= acc_q;
                REG_STATUS:    rdata_q <= status_q;
                REG_PC_LATCH:  rdata_q <= pc_latch_q;
                REG_PC_LO:     rdata_q <= pc_q[7:0];
                REG_PC_HI:     rdata_q <= {3'h0, pc_q[PC_W-1:8]};
                REG_CONTROL:   rdata_q <= control_q;
                REG_WDT_COUNT: rdata_q <= wdt_count;
                REG_EXEC:      rdata_q <= {5'h00, phase_q, flush_q};
                default:       rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // progress pulse
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cycle_done_q <= 1'b0;
        end else begin
            cycle_done_q <= commit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_reg_rdata  = rdata_q;
    assign o_fetch_pc   = pc_q;
    assign o_fetch_req  = fetch && !flush_q;
    assign o_stack_push = stack_push_q;
    assign o_stack_data = stack_data_q;
    assign o_cycle_done = cycle_done_q;

endmodule : byte_op_instruction_exec

// File: core/exec_pkg.sv
package exec_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int DATA_W         = 8;
    localparam int FILE_AW        = 7;
    localparam int FILE_DEPTH     = 128;
    localparam int PC_W           = 13;
    localparam int WORD_W         = 14;
    localparam int CALL_W         = 11;
    localparam int REG_AW         = 4;
    localparam int WDT_COUNT_W    = 8;
    localparam int WDT_PRESCALE_W = 7;

    ////////////////////////////////////////////////////////////////////////////
    // instruction word fields and encodings
    localparam int DEST_BIT    = 7;
    localparam int LATCH_HI    = 4;
    localparam int LATCH_LO    = 3;
    localparam logic [WORD_W-1:0] WORD_NOP           = 14'h0000;
    localparam logic [WORD_W-1:0] OP_CLEAR_WATCHDOG  = 14'h0064;
    localparam logic [WORD_W-1:0] MASK_BYTE_OP       = 14'h3f00;
    localparam logic [WORD_W-1:0] OP_COMPLEMENT_FILE = 14'h0900;
    localparam logic [WORD_W-1:0] OP_DECREMENT_FILE  = 14'h0300;
    localparam logic [WORD_W-1:0] OP_DEC_SKIP_ZERO   = 14'h0b00;
    localparam logic [WORD_W-1:0] MASK_CLEAR_OP      = 14'h3f80;
    localparam logic [WORD_W-1:0] OP_CLEAR_FILE      = 14'h0180;
    localparam logic [WORD_W-1:0] OP_CLEAR_ACC       = 14'h0100;
    localparam logic [WORD_W-1:0] MASK_CALL_OP       = 14'h3800;
    localparam logic [WORD_W-1:0] OP_CALL            = 14'h2000;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [REG_AW-1:0] REG_ACC       = 4'h0;
    localparam logic [REG_AW-1:0] REG_STATUS    = 4'h1;
    localparam logic [REG_AW-1:0] REG_PC_LATCH  = 4'h2;
    localparam logic [REG_AW-1:0] REG_PC_LO     = 4'h3;
    localparam logic [REG_AW-1:0] REG_PC_HI     = 4'h4;
    localparam logic [REG_AW-1:0] REG_CONTROL   = 4'h5;
    localparam logic [REG_AW-1:0] REG_WDT_COUNT = 4'h6;
    localparam logic [REG_AW-1:0] REG_EXEC      = 4'h7;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [DATA_W-1:0] ACC_RST      = 8'h00;
    localparam logic [DATA_W-1:0] STATUS_RST   = 8'h18;
    localparam logic [DATA_W-1:0] PC_LATCH_RST = 8'h00;
    localparam logic [DATA_W-1:0] CONTROL_RST  = 8'h01;
    localparam logic [PC_W-1:0]   PC_RST       = 13'h0000;
    localparam int                RUN_BIT      = 0;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {PH_FETCH, PH_READ, PH_EXEC, PH_COMMIT} phase_type;

    typedef enum logic [2:0] {
        OPK_NOP, OPK_CLEAR_WDT, OPK_CALL, OPK_COMPLEMENT,
        OPK_CLEAR_FILE, OPK_DECREMENT, OPK_CLEAR_ACC, OPK_DEC_SKIP
    } op_type;

    typedef struct packed {
        logic [2:0] bank;
        logic       watchdog_expiry_flag_n;
        logic       sleep_flag_n;
        logic       result_null_flag;
        logic       digit_carry;
        logic       carry;
    } status_type;

    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_type;

endpackage : exec_pkg

// File: core/file_ram.sv
`timescale 1ns/1ps
module file_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    // read port
    input  wire logic             i_rd_en,
    input  wire logic [AW-1:0]    i_rd_addr,
    output logic      [WIDTH-1:0] o_rd_data,
    // write port
    input  wire logic             i_wr_en,
    input  wire logic [AW-1:0]    i_wr_addr,
    input  wire logic [WIDTH-1:0] i_wr_data
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // storage
    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem_q[i_wr_addr] <= i_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered read
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rd_data <= '0;
        end else if (i_rd_en) begin
            o_rd_data <= mem_q[i_rd_addr];
        end
    end

endmodule : file_ram

// File: core/watchdog_count.sv
`timescale 1ns/1ps
module watchdog_count #(
    parameter int COUNT_W    = 8,
    parameter int PRESCALE_W = 7
) (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_nrst,
    // control
    input  wire logic               i_tick,
    input  wire logic               i_clear,
    // state
    output logic      [COUNT_W-1:0] o_count,
    output logic                    o_expire
);

    logic [PRESCALE_W-1:0] prescale_q;

    ////////////////////////////////////////////////////////////////////////////
    // prescaler then counter; clear wins over a tick
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prescale_q <= '0;
            o_count    <= '0;
            o_expire   <= 1'b0;
        end else begin
            o_expire <= 1'b0;
            if (i_clear) begin
                prescale_q <= '0;
                o_count    <= '0;
            end else if (i_tick) begin
                prescale_q <= prescale_q + 1'b1;
                if (&prescale_q) begin
                    o_count <= o_count + 1'b1;
                    if (&o_count) begin
                        o_expire <= 1'b1;
                    end
                end
            end
        end
    end

endmodule : watchdog_count

// File: testbench/exec_checker_sva.sv
`timescale 1ns/1ps
module exec_checker
    import exec_pkg::*;
(
    // clock and reset
    input wire logic                        i_clk,
    input wire logic                        i_nrst,
    // watched ports
    input wire logic                        i_reg_rd,
    input wire logic [exec_pkg::DATA_W-1:0] o_reg_rdata,
    input wire logic [exec_pkg::PC_W-1:0]   o_fetch_pc,
    input wire logic                        o_fetch_req,
    input wire logic [exec_pkg::WORD_W-1:0] i_fetch_word,
    input wire logic                        o_stack_push,
    input wire logic [exec_pkg::PC_W-1:0]   o_stack_data
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    ////////////////////////////////////////////////////////////////////////////
    // decode of the word taken at the end of a fetch phase
    logic            is_call;
    logic            is_skip;
    logic            is_plain;
    logic [PC_W-1:0] pc_q;
    assign is_call  = o_fetch_req && ((i_fetch_word & MASK_CALL_OP) == OP_CALL);
    assign is_skip  = o_fetch_req && ((i_fetch_word & MASK_BYTE_OP) == OP_DEC_SKIP_ZERO);
    assign is_plain = o_fetch_req && !is_call && !is_skip;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pc_q <= PC_RST;
        end else if (o_fetch_req) begin
            pc_q <= o_fetch_pc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    a_read_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_push_pulse: assert property (o_stack_push |=> !o_stack_push)
        else $error("stack push longer than one clock");
    a_push_hold: assert property (!o_stack_push |-> $stable(o_stack_data))
        else $error("stack data changed without push");
    a_call_push: assert property (is_call |-> ##[4:5] (o_stack_push && o_stack_data == pc_q + 13'h1))
        else $error("call did not push return address");
    a_call_target: assert property (is_call |-> ##4 o_fetch_pc[10:0] == $past(i_fetch_word[10:0], 4))
        else $error("call target low bits wrong");
    a_call_dead: assert property (is_call |-> ##1 (!o_fetch_req) [*7] ##1 o_fetch_req)
        else $error("call not two instruction cycles");
    a_plain_step: assert property (is_plain |-> ##4 o_fetch_pc == pc_q + 13'h1)
        else $error("single cycle instruction pc step wrong");
    a_plain_cycle: assert property (is_plain |-> ##1 (!o_fetch_req) [*3] ##1 o_fetch_req)
        else $error("single cycle instruction took longer");
    a_skip_path: assert property (is_skip |-> ##4 ((o_fetch_pc == pc_q + 13'h1 && o_fetch_req) or
        ((o_fetch_pc == pc_q + 13'h2 && !o_fetch_req) ##4 (o_fetch_req && o_fetch_pc == pc_q + 13'h2))))
        else $error("skip instruction path wrong");

    c_call: cover property (is_call ##5 !o_fetch_req);
    c_skip: cover property (is_skip ##4 o_fetch_pc == pc_q + 13'h2);
    c_read: cover property (i_reg_rd);
endmodule : exec_checker

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import exec_pkg::*;
    logic              i_clk;
    logic              i_nrst;
    logic [REG_AW-1:0] i_reg_addr;
    logic [DATA_W-1:0] i_reg_wdata;
    logic              i_reg_wr;
    logic              i_reg_rd;
    logic [DATA_W-1:0] o_reg_rdata;
    logic [PC_W-1:0]   o_fetch_pc;
    logic              o_fetch_req;
    logic [WORD_W-1:0] i_fetch_word;
    logic              o_stack_push;
    logic [PC_W-1:0]   o_stack_data;
    logic              o_cycle_done;
    int                n_fail;
    int                n_compared;
    logic [PC_W-1:0]   cur_pc;
    logic [PC_W-1:0]   done_pc;
    logic [DATA_W-1:0] rd_val;
    logic [REG_AW-1:0] idx_tbl [5] = '{REG_ACC, REG_STATUS, REG_PC_LATCH, REG_CONTROL, 4'hf};
    logic [DATA_W-1:0] rst_tbl [5] = '{ACC_RST, STATUS_RST, PC_LATCH_RST, CONTROL_RST, 8'h00};

    byte_op_instruction_exec dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .o_fetch_pc(o_fetch_pc), .o_fetch_req(o_fetch_req), .i_fetch_word(i_fetch_word),
        .o_stack_push(o_stack_push), .o_stack_data(o_stack_data), .o_cycle_done(o_cycle_done));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // tasks
    task results;
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    task check_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_data
    task check_pc(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_pc
    task reg_write(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_clk);
        i_reg_wr    <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [REG_AW-1:0] a);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_clk);
        i_reg_rd   <= 1'b0;
        @(negedge i_clk);
        rd_val = o_reg_rdata;
    endtask : reg_read
    // offers one word until a fetch phase takes it, then waits for its commit
    task issue(input logic [WORD_W-1:0] w, input int step);
        int n;
        n = 0;
        @(posedge i_clk);
        i_fetch_word <= w;
        @(negedge i_clk);
        while (o_fetch_req !== 1'b1 && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        cur_pc = o_fetch_pc;
        @(posedge i_clk);
        i_fetch_word <= WORD_NOP;
        repeat (2) @(negedge i_clk);
        while (o_cycle_done !== 1'b1 && n < 40) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 20) n_fail++;
        done_pc = o_fetch_pc;
        if (step > 0) check_pc(done_pc, cur_pc + PC_W'(step));
    endtask : issue
    task op(input logic [WORD_W-1:0] w, input logic [DATA_W-1:0] acc, input logic zf, input int step);
        issue(w, step);
        reg_read(REG_ACC);
        check_data(rd_val, acc);
        reg_read(REG_STATUS);
        check_data({7'h00, rd_val[2]}, {7'h00, zf});
    endtask : op

    ////////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        i_nrst = 1'b0;
        i_reg_addr = 4'h0;
        i_reg_wdata = 8'h00;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_fetch_word = WORD_NOP;
        n_fail = 0;
        n_compared = 0;
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            reg_read(idx_tbl[i]);
            check_data(rd_val, rst_tbl[i]);
        end
        reg_write(REG_ACC, 8'h5a);
        issue(OP_CLEAR_FILE | 14'h007f, 1);
        op(OP_CLEAR_FILE | 14'h0005, 8'h5a, 1'b1, 1);
        op(OP_DECREMENT_FILE | 14'h0005, 8'hff, 1'b0, 1);
        op(OP_DECREMENT_FILE | 14'h0085, 8'hff, 1'b0, 1);
        op(OP_COMPLEMENT_FILE | 14'h0005, 8'h00, 1'b1, 1);
        op(OP_COMPLEMENT_FILE | 14'h0085, 8'h00, 1'b1, 1);
        op(OP_DECREMENT_FILE | 14'h0085, 8'h00, 1'b0, 1);
        op(OP_DECREMENT_FILE | 14'h0085, 8'h00, 1'b0, 1);
        op(OP_COMPLEMENT_FILE | 14'h0085, 8'h00, 1'b0, 1);
        reg_write(REG_ACC, 8'h33);
        op(OP_CLEAR_ACC, 8'h00, 1'b1, 1);
        op(OP_DEC_SKIP_ZERO | 14'h007f, 8'hff, 1'b1, 1);
        op(OP_DECREMENT_FILE | 14'h007f, 8'hff, 1'b0, 1);
        op(OP_DEC_SKIP_ZERO | 14'h0085, 8'hff, 1'b0, 2);
        op(OP_DECREMENT_FILE | 14'h0005, 8'hff, 1'b0, 1);
        reg_write(REG_PC_LATCH, 8'h18);
        op(OP_CALL | 14'h07ff, 8'hff, 1'b0, 0);
        check_pc(done_pc, 13'h1fff);
        check_pc(o_stack_data, cur_pc + 13'h1);
        reg_write(REG_PC_LATCH, 8'he7);
        op(OP_CALL | 14'h0555, 8'hff, 1'b0, 0);
        check_pc(done_pc, 13'h0555);
        check_pc(o_stack_data, cur_pc + 13'h1);
        repeat (600) @(posedge i_clk);
        reg_write(REG_STATUS, 8'h00);
        reg_read(REG_STATUS);
        check_data(rd_val, 8'h00);
        issue(OP_CLEAR_WATCHDOG, 1);
        reg_read(REG_STATUS);
        check_data(rd_val, 8'h18);
        reg_read(REG_WDT_COUNT);
        check_data(rd_val, 8'h00);
        results();
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        results();
    end
endmodule : testbench

bind byte_op_instruction_exec exec_checker u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_fetch_pc(o_fetch_pc), .o_fetch_req(o_fetch_req),
    .i_fetch_word(i_fetch_word), .o_stack_push(o_stack_push), .o_stack_data(o_stack_data));
